// [core/cmo_ctrl.sv]
// Compare module output mode controller with AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps

`include "cmo_defines.svh"

module cmo_ctrl
  import cmo_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] counter_val,
  input  wire logic        counter_step,
  output logic             module_output_pin,
  output logic             irq
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Read value of a register, zero for unmapped offsets
  // Reserved bits are held at zero in the state, so they read back as zero
  function automatic logic [31:0] reg_read(input cmo_state_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `CMO_OFS_MODE:    v = {24'h00_0000, s.mode};
      `CMO_OFS_COMPARE: v = {16'h0000, s.compare};
      `CMO_OFS_STATUS:  v = {30'h0000_0000, s.status};
      `CMO_OFS_MASK:    v = {30'h0000_0000, s.mask};
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Operating mode from the mode register
  // Both waveform enables together take priority and select frequency output
  function automatic cmo_op_e op_decode(input cmo_mode_s m);
    cmo_op_e o;
    o = CMO_IDLE;
    if (m.match_toggle_en && m.pulse_mod_en)
      o = CMO_FREQ;
    else if (m.pulse_mod_en)
      o = m.wide_pulse_sel ? CMO_PWM16 : CMO_PWM8;
    else if (m.match_toggle_en)
      o = CMO_TOGGLE;
    return o;
  endfunction

  // ****************************************************************
  // State and next state
  // ****************************************************************
  // The whole block state lives in one register; nxt_st is its next value
  cmo_state_s st_ff;
  cmo_state_s nxt_st;

  // Combinational decode of the counter link and the bus
  logic        addr_take;
  logic        full_match;
  logic        low_match;
  logic        wrap;
  logic [1:0]  events;
  logic [31:0] rd_val;
  cmo_op_e     op;

  // ****************************************************************
  // Compare events and bus decode
  // ****************************************************************
  // Counter compare events, qualified by the counter advance pulse
  assign full_match = counter_step && (counter_val == st_ff.compare);
  assign wrap       = counter_step && (counter_val == 16'h0000);
  assign op         = op_decode(st_ff.mode);
  // Word transfers only, so hsize and the upper address bits are not decoded
  assign addr_take  = hsel && hready && htrans[1];

  // Next state: register writes, read-clear, pin waveform, interrupt
  always_comb
  begin
    nxt_st           = st_ff;
    rd_val           = 32'h0000_0000;
    events           = 2'h0;
    low_match        = 1'b0;
    nxt_st.hreadyout = 1'b1;

    // Data phase of a pending write lands first so a following read sees it
    if (st_ff.wr_pend)
    begin
      unique case (st_ff.wr_addr)
        `CMO_OFS_MODE:    nxt_st.mode    = hwdata[`CMO_MODE_W-1:0];
        `CMO_OFS_COMPARE: nxt_st.compare = hwdata[15:0];
        `CMO_OFS_MASK:    nxt_st.mask    = hwdata[`CMO_ST_W-1:0];
        default:          nxt_st.mode    = nxt_st.mode;
      endcase
    end
    // Reserved mode bits never hold a one
    nxt_st.mode.reserved = 3'h0;

    // Match flag and wrap events
    events[`CMO_ST_MATCH] = full_match && st_ff.mode.match_det_en;
    events[`CMO_ST_WRAP]  = wrap;

    // Output pin per operating mode
    unique case (op)
      CMO_TOGGLE:
      begin
        // Invert on each full 16-bit match
        if (full_match)
          nxt_st.pin = ~st_ff.pin;
      end
      CMO_PWM8:
      begin
        // Low counter byte against the high compare byte sets the duty
        if (counter_step)
          nxt_st.pin = (counter_val[7:0] >= st_ff.compare[15:8]);
      end
      CMO_PWM16:
      begin
        // Full counter against the full compare value sets the duty
        if (counter_step)
          nxt_st.pin = (counter_val >= st_ff.compare);
      end
      CMO_FREQ:
      begin
        // Invert at each hit of the target, then move the target on by one half period
        low_match = counter_step && (counter_val[7:0] == st_ff.freq_next);
        if (low_match)
        begin
          nxt_st.pin       = ~st_ff.pin;
          nxt_st.freq_next = st_ff.freq_next + st_ff.compare[15:8];
        end
      end
      CMO_IDLE:
      begin
        // No waveform function: the pin keeps its last level
        nxt_st.pin = st_ff.pin;
      end
    endcase

    // A compare write reloads the frequency target after the waveform update, so
    // software wins over a frequency hit that falls in the same cycle
    if (st_ff.wr_pend && st_ff.wr_addr == `CMO_OFS_COMPARE)
      nxt_st.freq_next = hwdata[15:8];

    // Address phase: capture reads, queue writes
    // No wait states: read data are loaded at the address edge and stand in the data
    // phase; a write landing in the same cycle is seen through nxt_st
    nxt_st.wr_pend = 1'b0;
    if (addr_take)
    begin
      if (hwrite)
      begin
        nxt_st.wr_pend = 1'b1;
        nxt_st.wr_addr = haddr[`CMO_ADDR_W-1:0];
      end
      else
      begin
        rd_val        = reg_read(nxt_st, haddr[`CMO_ADDR_W-1:0]);
        nxt_st.hrdata = rd_val;
      end
    end

    // Sticky status: read clears what was returned, a new event wins
    // An event in the clearing cycle stays set for the next read
    if (addr_take && !hwrite && haddr[`CMO_ADDR_W-1:0] == `CMO_OFS_STATUS)
      nxt_st.status = (st_ff.status & ~rd_val[`CMO_ST_W-1:0]) | events;
    else
      nxt_st.status = st_ff.status | events;

    // Interrupt: mask register, match flag additionally gated by its enable
    // The wrap event is gated by its mask bit only; irq moves with the status bits
    nxt_st.irq = (nxt_st.status[`CMO_ST_MATCH] && nxt_st.mask[`CMO_ST_MATCH]
                  && nxt_st.mode.match_flag_irq_en)
               || (nxt_st.status[`CMO_ST_WRAP] && nxt_st.mask[`CMO_ST_WRAP]);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff           <= '0;
      st_ff.mode      <= `CMO_RST_MODE;
      st_ff.compare   <= `CMO_RST_COMPARE;
      st_ff.status    <= `CMO_RST_STATUS;
      st_ff.mask      <= `CMO_RST_MASK;
      st_ff.pin       <= `CMO_RST_PIN;
      // Ready high out of reset: the slave never inserts wait states
      st_ff.hreadyout <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs from the state register, except hresp which is tied to OKAY
  // ****************************************************************
  // Nothing combinational reaches a port, so outputs never glitch
  assign hrdata            = st_ff.hrdata;
  assign hreadyout         = st_ff.hreadyout;
  assign hresp             = 1'b0;              // Always OKAY
  assign module_output_pin = st_ff.pin;
  assign irq               = st_ff.irq;

endmodule

// [core/cmo_defines.svh]
// Register offsets, field positions, reset values and widths of the output mode controller
`ifndef CMO_DEFINES_SVH
`define CMO_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CMO_OFS_MODE        8'h00
`define CMO_OFS_COMPARE     8'h04
`define CMO_OFS_STATUS      8'h08
`define CMO_OFS_MASK        8'h0c
`define CMO_ADDR_W          8

// ****************************************************************
// Mode register fields
// ****************************************************************
`define CMO_BIT_IRQ_EN      0
`define CMO_BIT_PULSE_EN    1
`define CMO_BIT_TOGGLE_EN   2
`define CMO_BIT_MATCH_EN    3
`define CMO_BIT_WIDE_SEL    7
`define CMO_MODE_W          8

// ****************************************************************
// Status and mask fields
// ****************************************************************
`define CMO_ST_MATCH        0
`define CMO_ST_WRAP         1
`define CMO_ST_W            2

// ****************************************************************
// Reset values
// ****************************************************************
`define CMO_RST_MODE        8'h00
`define CMO_RST_COMPARE     16'h0000
`define CMO_RST_STATUS      2'h0
`define CMO_RST_MASK        2'h0
`define CMO_RST_PIN         1'b0

`endif

// [core/cmo_pkg.sv]
// Types shared by the output mode controller
package cmo_pkg;

  // Mode register layout
  typedef struct packed {
    logic       wide_pulse_sel;
    logic [2:0] reserved;
    logic       match_det_en;
    logic       match_toggle_en;
    logic       pulse_mod_en;
    logic       match_flag_irq_en;
  } cmo_mode_s;

  // Operating mode decoded from the enables
  typedef enum logic [2:0] {
    CMO_IDLE,
    CMO_TOGGLE,
    CMO_PWM8,
    CMO_PWM16,
    CMO_FREQ
  } cmo_op_e;

  // Whole state of the controller
  typedef struct packed {
    cmo_mode_s   mode;
    logic [15:0] compare;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [7:0]  freq_next;
    logic        pin;
    logic        irq;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
  } cmo_state_s;

endpackage

// [testbench/cmo_ctrl_chk.sv]
// Port checker of the output mode controller
`timescale 1ns/1ps
`include "cmo_defines.svh"
module cmo_ctrl_chk
  import cmo_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] counter_val,
  input wire logic        counter_step,
  input wire logic        module_output_pin,
  input wire logic        irq
);
  logic [7:0]  md_ff;
  logic [15:0] cp_ff;
  logic [7:0]  fn_ff;
  logic [7:0]  wa_ff;
  logic [1:0]  mk_ff;
  logic        wp_ff;
  logic        ie;
  logic        e8;
  logic        e16;
  logic        fh;
  assign ie = md_ff[0];
  assign e8 = counter_val[7:0] >= cp_ff[15:8];
  assign e16 = counter_val >= cp_ff;
  assign fh = counter_val[7:0] == fn_ff;
  // Shadow registers rebuilt from bus writes; frequency target follows steps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      md_ff <= 8'h00;
      cp_ff <= 16'h0000;
      fn_ff <= 8'h00;
      mk_ff <= 2'h0;
      wp_ff <= 1'b0;
      wa_ff <= 8'h00;
    end
    else
    begin
      wp_ff <= hsel & hready & htrans[1] & hwrite;
      wa_ff <= haddr[7:0];
      if (wp_ff && wa_ff == `CMO_OFS_MODE) md_ff <= hwdata[7:0];
      if (wp_ff && wa_ff == `CMO_OFS_MASK) mk_ff <= hwdata[1:0];
      if (wp_ff && wa_ff == `CMO_OFS_COMPARE) cp_ff <= hwdata[15:0];
      if (wp_ff && wa_ff == `CMO_OFS_COMPARE) fn_ff <= hwdata[15:8];
      else if (counter_step && md_ff[2] && md_ff[1] && fh) fn_ff <= fn_ff + cp_ff[15:8];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_toggle_inv:
    assert property (counter_step && md_ff[2:1] == 2'h2 && counter_val == cp_ff |=>
      module_output_pin != $past(module_output_pin)) else $error("pin did not invert");
  chk_freq_out:
    assert property (counter_step && md_ff[2:1] == 2'h3 |=>
      module_output_pin == ($past(module_output_pin) ^ $past(fh))) else $error("frequency output wrong");
  chk_pin_hold:
    assert property (!counter_step || md_ff[2:1] == 2'h0 |=> $stable(module_output_pin))
      else $error("pin moved without cause");
  chk_pwm8_level:
    assert property (counter_step && md_ff[2:1] == 2'h1 && !md_ff[7] |=> module_output_pin == $past(e8))
      else $error("8-bit pulse level wrong");
  chk_pwm16_level:
    assert property (counter_step && md_ff[2:1] == 2'h1 && md_ff[7] |=> module_output_pin == $past(e16))
      else $error("16-bit pulse level wrong");
  chk_irq_masked:
    assert property (!(ie && mk_ff[0]) && !mk_ff[1] |-> !irq) else $error("interrupt while disabled");
  chk_flag_irq:
    assert property (counter_step && counter_val == cp_ff && md_ff[3] && ie && mk_ff[0] |=> irq)
      else $error("match raised no interrupt");
  chk_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus stalled or errored");
endmodule

// [testbench/cmo_ctrl_tb.sv]
// Self-checking bench of the output mode controller
`timescale 1ns/1ps
`include "cmo_defines.svh"
module cmo_ctrl_tb
  import cmo_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] counter_val = 16'h0;
  logic        counter_step = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pin, irq;
  logic [7:0]  md = 8'h0, fn = 8'h0;
  logic [15:0] cp = 16'h0, v;
  logic        ep = 1'b0;
  logic [31:0] q;
  logic [7:0]  mt [5] = '{8'h04, 8'h02, 8'h82, 8'h76, 8'h80};
  int          err_count = 0;
  int          total_checks = 0;
  always #25 hclk = ~hclk;
  cmo_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .counter_val, .counter_step, .module_output_pin(pin), .irq);
  // Compare one value and count it
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single AHB transfer; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    if (w && a == `CMO_OFS_MODE) md = d[7:0];
    if (w && a == `CMO_OFS_COMPARE) {cp, fn} = {d[15:0], d[15:8]};
  endtask
  // Expected pin after a step at value x
  function logic nxt_pin(input logic [15:0] x);
    logic hit;
    hit = (x[7:0] == fn);
    if (md[2:1] == 2'h3)
    begin
      if (hit)
        fn += cp[15:8];
      return ep ^ hit;
    end
    if (md[2:1] == 2'h2)
      return ep ^ (x == cp);
    if (md[2:1] == 2'h1)
      return md[7] ? x >= cp : x[7:0] >= cp[15:8];
    return ep;
  endfunction
  // One counter step, then check the pin
  task stp(input logic [15:0] x);
    @(posedge hclk);
    counter_val <= x;
    counter_step <= 1'b1;
    @(posedge hclk);
    counter_step <= 1'b0;
    ep = nxt_pin(x);
    #1;
    chk("pin", ep, pin);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence: modes, interrupt path, unmapped access
  initial
  begin
    void'($urandom(21));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("reset pin", 32'h0, pin);
    foreach (mt[i])
    begin
      bus(1'b1, `CMO_OFS_MODE, mt[i]);
      bus(1'b1, `CMO_OFS_COMPARE, $urandom);
      bus(1'b0, `CMO_OFS_MODE, 32'h0);
      chk("mode", mt[i] & 8'h8f, q);
      bus(1'b0, `CMO_OFS_COMPARE, 32'h0);
      chk("compare", {16'h0, cp}, q);
      repeat (40)
      begin
        v = 16'($urandom);
        if ($urandom_range(2) == 0) v = (md[2:1] == 2'h3) ? {v[15:8], fn} : cp;
        stp(v);
      end
      $display("mode %h test done", mt[i]);
    end
    bus(1'b1, `CMO_OFS_MASK, 32'h1);
    bus(1'b1, `CMO_OFS_MODE, 32'h09);
    stp(cp);
    chk("irq", 32'h1, irq);
    bus(1'b0, `CMO_OFS_STATUS, 32'h0);
    chk("flag", 32'h1, q[0]);
    @(posedge hclk);
    #1;
    chk("irq", 32'h0, irq);
    bus(1'b1, `CMO_OFS_MODE, 32'h08);
    stp(cp);
    chk("irq", 32'h0, irq);
    bus(1'b0, `CMO_OFS_STATUS, 32'h0);
    chk("flag", 32'h1, q[0]);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `CMO_OFS_MASK, 32'h2);
    bus(1'b0, `CMO_OFS_MASK, 32'h0);
    chk("mask", 32'h2, q);
    stp(16'h0000);
    chk("wrap irq", 32'h1, irq);
    bus(1'b0, `CMO_OFS_STATUS, 32'h0);
    chk("wrap", 32'h2, q & 32'h2);
    $display("interrupt test done");
    print_verdict;
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("wrong value watchdog expected done seen hang");
    print_verdict;
  end
endmodule
bind cmo_ctrl cmo_ctrl_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .counter_val, .counter_step, .module_output_pin, .irq);
